// ===== rtl/acs_pkg.sv
// shared types and constants of the converter control block
package acs_pkg;
  typedef struct packed {
    logic single_ended_select;
    logic [2:0] channel_select;
    logic [1:0] power_manage;
    logic [1:0] read_source;
    logic interface_mode;
    logic conversion_launch;
    logic calibration_kind;
    logic [1:0] calibration_choice;
    logic calibration_launch;
  } acs_ctrl_t;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
  } acs_mux_t;

  typedef enum logic [3:0] {
    CS_IDLE = 4'h1,
    CS_DAC = 4'h2,
    CS_GAIN = 4'h4,
    CS_OFFS = 4'h8
  } acs_cal_state_t;

  localparam acs_ctrl_t CTRL_RST = 14'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [1:0] RD_STATUS = 2'h3;
  localparam logic [1:0] CAL_FULL = 2'h0;
  localparam logic [1:0] CAL_GAIN_OFFS = 2'h1;
  localparam logic [1:0] CAL_OFFS_ONLY = 2'h2;
  localparam logic [1:0] CAL_GAIN_ONLY = 2'h3;
  localparam logic [3:0] AIN_GND = 4'h0;
  localparam acs_mux_t MUX_RST = 8'h12;
  localparam int ST_ZERO = 15;
  localparam int ST_BUSY = 14;
  localparam int ST_CH_HI = 13;
  localparam int ST_CH_LO = 10;
  localparam int ST_PM_HI = 9;
  localparam int ST_PM_LO = 8;
  localparam int ST_RD_HI = 7;
  localparam int ST_RD_LO = 6;
  localparam int ST_MODE = 5;
  localparam int ST_DONTCARE = 4;
  localparam int ST_KIND = 3;
  localparam int ST_CHOICE_HI = 2;
  localparam int ST_CHOICE_LO = 1;
  localparam int ST_CAL = 0;
endpackage

// ===== rtl/acs_mux_dec.sv
// input multiplexer decode from single-ended select and channel code
`timescale 1ns/1ps
`default_nettype none
module acs_mux_dec (
  input wire logic se_i,
  input wire logic [2:0] ch_i,
  output acs_pkg::acs_mux_t mux_o
);
  import acs_pkg::*;
  logic [3:0] odd_in;
  logic [3:0] even_in;

  always_comb begin
    odd_in = {1'b0, ch_i[1:0], 1'b1};
    even_in = odd_in + 4'h1;
    if (se_i) begin
      mux_o.pos = ch_i[2] ? even_in : odd_in; // RULE_02
      mux_o.neg = AIN_GND; // RULE_02
    end else begin
      mux_o.pos = ch_i[2] ? even_in : odd_in; // RULE_01
      mux_o.neg = ch_i[2] ? odd_in : even_in; // RULE_01
    end
  end
endmodule
`default_nettype wire

// ===== rtl/acs_cal_seq.sv
// calibration step sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_cal_seq (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [1:0] choice_i,
  input wire logic step_done_i,
  output acs_pkg::acs_cal_state_t state_o,
  output logic step_start_o,
  output logic done_o
);
  import acs_pkg::*;
  acs_cal_state_t state_ff, nxt_state_ff;
  logic [1:0] choice_ff, nxt_choice_ff;
  logic start_ff, nxt_start_ff;
  logic done_ff, nxt_done_ff;

  always_comb begin
    nxt_state_ff = state_ff;
    nxt_choice_ff = choice_ff;
    nxt_start_ff = 1'b0;
    nxt_done_ff = 1'b0;
    case (state_ff)
      CS_IDLE: begin
        if (start_i) begin
          nxt_choice_ff = choice_i;
          nxt_start_ff = 1'b1;
          if (choice_i == CAL_FULL) begin
            nxt_state_ff = CS_DAC; // RULE_03
          end else if (choice_i == CAL_OFFS_ONLY) begin
            nxt_state_ff = CS_OFFS; // RULE_05
          end else begin
            nxt_state_ff = CS_GAIN; // RULE_04
          end
        end
      end
      CS_DAC: begin
        if (step_done_i) begin
          nxt_state_ff = CS_GAIN; // RULE_03
          nxt_start_ff = 1'b1;
        end
      end
      CS_GAIN: begin
        if (step_done_i) begin
          if (choice_ff == CAL_GAIN_ONLY) begin
            nxt_state_ff = CS_IDLE; // RULE_06
            nxt_done_ff = 1'b1;
          end else begin
            nxt_state_ff = CS_OFFS; // RULE_23
            nxt_start_ff = 1'b1;
          end
        end
      end
      CS_OFFS: begin
        if (step_done_i) begin
          nxt_state_ff = CS_IDLE; // RULE_23
          nxt_done_ff = 1'b1;
        end
      end
      default: begin
        nxt_state_ff = CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= CS_IDLE;
      choice_ff <= CAL_FULL;
      start_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state_ff;
      choice_ff <= nxt_choice_ff;
      start_ff <= nxt_start_ff;
      done_ff <= nxt_done_ff;
    end
  end

  assign state_o = state_ff;
  assign step_start_o = start_ff;
  assign done_o = done_ff;
endmodule
`default_nettype wire

// ===== rtl/acs_adc_ctrl.sv
// converter control word, channel and calibration decode, status word
//////////////////////////////////////////////////////////////////////////
// Function
// RULE_01: differential codes pair odd/even inputs, swap on bit2
// RULE_02: single-ended uses ground as negative input
// RULE_03: mode0 choice00 runs dac, gain, offset
// RULE_04: choice01 runs gain then offset
// RULE_05: choice10 runs offset only
// RULE_06: choice11 runs gain only
// RULE_07: mode1 choice00 runs dac, system gain, offset
// RULE_08: status bit3 reports calibration mode
// RULE_09: status returned only with read source 11
// RULE_10: status word clears to zero at reset
// RULE_11: status bit15 always zero
// RULE_12: status bit14 shows conversion or calibration busy
// RULE_13: status bits13-10 echo channel selection
// RULE_14: status bits9-8 echo power management bits
// RULE_15: status bits7-6 read one when returned
// RULE_16: bit5 interface mode, cleared after each read
// RULE_17: status bit0 shows calibration in progress
// RULE_18: status bits2-1 echo calibration choice
// RULE_19: calibration launch clears when sequence finishes
// RULE_20: conversion launch starts one, clears at end
// RULE_21: reset channel is input1 against input2
// RULE_22: status bit4 reads zero
// RULE_23: only selected steps run, busy until last
//////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module acs_adc_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ctrl_wr_i,
  input wire acs_pkg::acs_ctrl_t ctrl_data_i,
  input wire logic rd_done_i,
  input wire logic conv_done_i,
  input wire logic cal_step_done_i,
  output logic [15:0] status_o,
  output logic status_sel_o,
  output acs_pkg::acs_mux_t mux_o,
  output logic conv_start_o,
  output logic cal_step_start_o,
  output acs_pkg::acs_cal_state_t cal_step_o,
  output logic cal_system_o
);
  import acs_pkg::*;

  acs_ctrl_t ctrl_ff, nxt_ctrl_ff;
  logic [15:0] status_ff, nxt_status_ff;
  acs_mux_t mux_ff;
  acs_mux_t nxt_mux_ff;
  logic conv_start_ff, nxt_conv_start_ff;
  logic sel_ff, nxt_sel_ff;
  logic system_ff, nxt_system_ff;
  logic busy_any;
  logic cal_go;
  logic conv_go;
  logic cal_done;
  acs_mux_t mux_dec;

  //////////////////////////////////////////////////////////////////////////
  // control word

  // a launch is refused while anything runs, so a launch bit is only ever
  // set when the matching engine really starts and is sure to clear again
  always_comb begin
    busy_any = ctrl_ff.conversion_launch | ctrl_ff.calibration_launch;
    cal_go = ctrl_wr_i & ctrl_data_i.calibration_launch & ~busy_any;
    conv_go = ctrl_wr_i & ctrl_data_i.conversion_launch & ~busy_any
      & ~ctrl_data_i.calibration_launch;
  end

  always_comb begin
    nxt_ctrl_ff = ctrl_ff;
    if (rd_done_i) begin
      nxt_ctrl_ff.interface_mode = 1'b0; // RULE_16
    end
    if (ctrl_wr_i) begin
      nxt_ctrl_ff = ctrl_data_i;
    end
    // a launch written in the end-of-run cycle is refused, so the clear takes effect
    nxt_ctrl_ff.calibration_launch = cal_go
      | (ctrl_ff.calibration_launch & ~cal_done); // RULE_19
    nxt_ctrl_ff.conversion_launch = conv_go
      | (ctrl_ff.conversion_launch & ~conv_done_i); // RULE_20
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= CTRL_RST; // RULE_21
    end else begin
      ctrl_ff <= nxt_ctrl_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // channel decode and calibration sequencer

  acs_mux_dec u_mux (
    .se_i(ctrl_ff.single_ended_select),
    .ch_i(ctrl_ff.channel_select),
    .mux_o(mux_dec)
  );

  acs_cal_seq u_seq (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(cal_go),
    .choice_i(ctrl_data_i.calibration_choice),
    .step_done_i(cal_step_done_i),
    .state_o(cal_step_o),
    .step_start_o(cal_step_start_o),
    .done_o(cal_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // status word and registered outputs

  always_comb begin
    nxt_mux_ff = mux_dec;
    nxt_conv_start_ff = conv_go; // RULE_20
    nxt_sel_ff = (ctrl_ff.read_source == RD_STATUS); // RULE_09
    nxt_system_ff = cal_go ? ctrl_data_i.calibration_kind : system_ff; // RULE_07
    nxt_status_ff = STATUS_RST;
    nxt_status_ff[ST_ZERO] = 1'b0; // RULE_11
    nxt_status_ff[ST_BUSY] = busy_any; // RULE_12
    nxt_status_ff[ST_CH_HI:ST_CH_LO] = {ctrl_ff.single_ended_select,
      ctrl_ff.channel_select}; // RULE_13
    nxt_status_ff[ST_PM_HI:ST_PM_LO] = ctrl_ff.power_manage; // RULE_14
    // equals 11 whenever the word is the one selected for reading
    nxt_status_ff[ST_RD_HI:ST_RD_LO] = ctrl_ff.read_source; // RULE_15
    nxt_status_ff[ST_MODE] = ctrl_ff.interface_mode; // RULE_16
    nxt_status_ff[ST_DONTCARE] = 1'b0; // RULE_22
    nxt_status_ff[ST_KIND] = ctrl_ff.calibration_kind; // RULE_08
    nxt_status_ff[ST_CHOICE_HI:ST_CHOICE_LO] =
      ctrl_ff.calibration_choice; // RULE_18
    nxt_status_ff[ST_CAL] = ctrl_ff.calibration_launch; // RULE_17
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_ff <= STATUS_RST; // RULE_10
      mux_ff <= MUX_RST; // RULE_21
      conv_start_ff <= 1'b0;
      sel_ff <= 1'b0;
      system_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status_ff;
      mux_ff <= nxt_mux_ff;
      conv_start_ff <= nxt_conv_start_ff;
      sel_ff <= nxt_sel_ff;
      system_ff <= nxt_system_ff;
    end
  end

  assign status_o = status_ff;
  assign status_sel_o = sel_ff;
  assign mux_o = mux_ff;
  assign conv_start_o = conv_start_ff;
  assign cal_system_o = system_ff;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_diff_pair;
    (!ctrl_ff.single_ended_select && !ctrl_ff.channel_select[2])
      |=> (mux_o.pos[0] == 1'b1) && (mux_o.neg == mux_o.pos + 4'h1);
  endproperty
  a_diff_pair: assert property (p_diff_pair) else $error("bad pair"); // RULE_01

  property p_single_gnd;
    ctrl_ff.single_ended_select |=> mux_o.neg == AIN_GND;
  endproperty
  a_single_gnd: assert property (p_single_gnd) else $error("neg not gnd"); // RULE_02

  sequence s_full_go;
    cal_go && ctrl_data_i.calibration_choice == CAL_FULL;
  endsequence
  sequence s_dac_step;
    cal_step_o == CS_DAC && cal_step_done_i;
  endsequence

  property p_full_first;
    s_full_go |=> cal_step_o == CS_DAC && cal_step_start_o;
  endproperty
  a_full_first: assert property (p_full_first) else $error("no dac first"); // RULE_03

  property p_dac_then_gain;
    s_dac_step |=> cal_step_o == CS_GAIN ##0 cal_step_start_o;
  endproperty
  a_dac_then_gain: assert property (p_dac_then_gain) else $error("no gain"); // RULE_23

  property p_offs_only;
    cal_go && ctrl_data_i.calibration_choice == CAL_OFFS_ONLY
      |=> cal_step_o == CS_OFFS;
  endproperty
  a_offs_only: assert property (p_offs_only) else $error("not offset"); // RULE_05

  property p_kind;
    cal_go |=> cal_system_o == $past(ctrl_data_i.calibration_kind);
  endproperty
  a_kind: assert property (p_kind) else $error("kind lost"); // RULE_07

  property p_zero_bits;
    !status_o[ST_ZERO] && !status_o[ST_DONTCARE];
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("bit not zero"); // RULE_11

  property p_busy;
    busy_any |=> status_o[ST_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy missing"); // RULE_12

  property p_src;
    ctrl_ff.read_source == RD_STATUS
      |=> status_o[ST_RD_HI:ST_RD_LO] == 2'h3 && status_sel_o;
  endproperty
  a_src: assert property (p_src) else $error("source bits"); // RULE_15

  property p_mode_clear;
    rd_done_i && !ctrl_wr_i |=> !ctrl_ff.interface_mode ##1 !status_o[ST_MODE];
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode kept"); // RULE_16

  property p_conv_end;
    ctrl_ff.conversion_launch && conv_done_i && !ctrl_wr_i
      |=> !ctrl_ff.conversion_launch;
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("conv stuck"); // RULE_20

  property p_cal_end;
    cal_done && !ctrl_wr_i |=> !ctrl_ff.calibration_launch ##1 !status_o[ST_CAL];
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("cal stuck"); // RULE_19

  property p_conv_pulse;
    conv_go |=> conv_start_o ##1 !conv_start_o;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("no start"); // RULE_20

  property p_diff_swap;
    (!ctrl_ff.single_ended_select && ctrl_ff.channel_select[2])
      |=> (mux_o.neg[0] == 1'b1) && (mux_o.pos == mux_o.neg + 4'h1);
  endproperty
  a_diff_swap: assert property (p_diff_swap) else $error("bad swap"); // RULE_01

  property p_single_pos;
    ctrl_ff.single_ended_select
      |=> mux_o.pos != AIN_GND && mux_o.pos[0] != $past(ctrl_ff.channel_select[2]);
  endproperty
  a_single_pos: assert property (p_single_pos) else $error("bad single pos"); // RULE_02

  // a step may only hand over to a later step or back to idle
  sequence s_gain_step;
    cal_step_o == CS_GAIN && cal_step_done_i;
  endsequence
  sequence s_offs_step;
    cal_step_o == CS_OFFS && cal_step_done_i;
  endsequence

  property p_pair_first;
    cal_go && ctrl_data_i.calibration_choice == CAL_GAIN_OFFS
      |=> cal_step_o == CS_GAIN && cal_step_start_o;
  endproperty
  a_pair_first: assert property (p_pair_first) else $error("no gain first"); // RULE_04

  property p_gain_only;
    cal_go && ctrl_data_i.calibration_choice == CAL_GAIN_ONLY
      |=> cal_step_o == CS_GAIN && cal_step_start_o;
  endproperty
  a_gain_only: assert property (p_gain_only) else $error("no gain step"); // RULE_06

  property p_gain_next;
    s_gain_step |=> cal_step_o == CS_IDLE
      || (cal_step_o == CS_OFFS && cal_step_start_o);
  endproperty
  a_gain_next: assert property (p_gain_next) else $error("bad after gain"); // RULE_23

  property p_offs_last;
    s_offs_step |=> (cal_step_o == CS_IDLE && cal_done) ##1 !ctrl_ff.calibration_launch;
  endproperty
  a_offs_last: assert property (p_offs_last) else $error("offset not last"); // RULE_23

  property p_cal_hold;
    cal_step_o != CS_IDLE
      |-> ctrl_ff.calibration_launch ##1 (status_o[ST_CAL] && status_o[ST_BUSY]);
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("cal flag dropped"); // RULE_17

  property p_busy_drop;
    !busy_any |=> !status_o[ST_BUSY];
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy stuck"); // RULE_12

  property p_refuse_conv;
    busy_any |=> !conv_start_o;
  endproperty
  a_refuse_conv: assert property (p_refuse_conv) else $error("conv while busy"); // RULE_20

  // a late launch must not restart the sequencer before the flag has cleared
  property p_refuse_cal;
    busy_any && cal_step_o == CS_IDLE |=> cal_step_o == CS_IDLE;
  endproperty
  a_refuse_cal: assert property (p_refuse_cal) else $error("cal while busy"); // RULE_19

  property p_chan_echo;
    status_o[ST_CH_HI:ST_CH_LO]
      == $past({ctrl_ff.single_ended_select, ctrl_ff.channel_select});
  endproperty
  a_chan_echo: assert property (p_chan_echo) else $error("channel echo"); // RULE_13

  property p_pm_echo;
    status_o[ST_PM_HI:ST_PM_LO]
      == $past(ctrl_ff.power_manage);
  endproperty
  a_pm_echo: assert property (p_pm_echo) else $error("power echo"); // RULE_14

  property p_kind_echo;
    status_o[ST_KIND]
      == $past(ctrl_ff.calibration_kind);
  endproperty
  a_kind_echo: assert property (p_kind_echo) else $error("kind echo"); // RULE_08

  property p_choice_echo;
    status_o[ST_CHOICE_HI:ST_CHOICE_LO]
      == $past(ctrl_ff.calibration_choice);
  endproperty
  a_choice_echo: assert property (p_choice_echo) else $error("choice echo"); // RULE_18
endmodule
`default_nettype wire

// ===== verif/acs_far_model.sv
// far-side model: answers conversion and calibration step starts
`timescale 1ns/1ps
`default_nettype none
module acs_far_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic conv_start_i,
  input wire logic step_start_i,
  input wire logic [3:0] delay_i,
  output logic conv_done_o,
  output logic step_done_o
);
  int conv_cnt;
  int step_cnt;
  ////////////////////////////////////////////////////////////////////////
  // delay 1 is the shortest answer: done rises on the second edge after the start pulse shows
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_cnt <= 0;
      step_cnt <= 0;
      conv_done_o <= 1'b0;
      step_done_o <= 1'b0;
    end else begin
      conv_done_o <= (conv_cnt == 1);
      step_done_o <= (step_cnt == 1);
      conv_cnt <= conv_start_i ? int'(delay_i) : (conv_cnt > 0 ? conv_cnt - 1 : 0);
      // one done per step only
      step_cnt <= step_start_i ? int'(delay_i) : (step_cnt > 0 ? step_cnt - 1 : 0);
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_acs_adc_ctrl.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_acs_adc_ctrl;
  import acs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ctrl_wr = 1'b0;
  acs_ctrl_t ctrl = CTRL_RST;
  logic rd_done = 1'b0;
  logic [3:0] delay = 4'h1;
  logic [15:0] status;
  logic status_sel;
  acs_mux_t mux;
  logic conv_start;
  logic step_start;
  acs_cal_state_t step;
  logic cal_sys;
  logic conv_done;
  logic step_done;
  int failures = 0;
  int checks = 0;
  acs_cal_state_t got_q[$];
  acs_cal_state_t exp_q[$];
  ////////////////////////////////////////////////////////////////////////
  always #10 clk_sys_i = ~clk_sys_i;
  acs_adc_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ctrl_wr_i(ctrl_wr),
    .ctrl_data_i(ctrl), .rd_done_i(rd_done), .conv_done_i(conv_done),
    .cal_step_done_i(step_done), .status_o(status), .status_sel_o(status_sel),
    .mux_o(mux), .conv_start_o(conv_start), .cal_step_start_o(step_start),
    .cal_step_o(step), .cal_system_o(cal_sys));
  acs_far_model far (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .conv_start_i(conv_start),
    .step_start_i(step_start), .delay_i(delay), .conv_done_o(conv_done),
    .step_done_o(step_done));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_mux(input int se, input int ch);
    int odd;
    int even;
    odd = 2 * (ch % 4) + 1;
    even = odd + 1;
    if (se != 0) return 8'((ch >= 4 ? even : odd) * 16);
    return 8'(ch >= 4 ? even * 16 + odd : odd * 16 + even);
  endfunction
  function automatic logic [15:0] exp_status(input acs_ctrl_t c, input int busy, input int cal);
    return 16'(busy * 16384 + c.single_ended_select * 8192 + c.channel_select * 1024 +
      c.power_manage * 256 + c.read_source * 64 + c.interface_mode * 32 +
      c.calibration_kind * 8 + c.calibration_choice * 2 + cal);
  endfunction
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_step(input acs_cal_state_t got, input acs_cal_state_t exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: step %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out;
    failures++;
    $display("wrong value at %0t: wait ran out", $time);
    conclude();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // returns just after the capture edge, where start pulses already show
  task automatic wr(input acs_ctrl_t w);
    tick(1);
    ctrl = w;
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 60; k++) begin
      if (status[ST_BUSY] === 1'b0) return;
      tick(1);
    end
    timed_out();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    acs_ctrl_t c;
    int k;
    void'($urandom(16988));
    tick(16);
    rst_n_i = 1'b1;
    tick(1);
    cmp_val(status, STATUS_RST);
    cmp_val(16'(mux), 16'h0012);
    cmp_step(step, CS_IDLE);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      c = CTRL_RST;
      {c.single_ended_select, c.channel_select} = 4'(i);
      wr(c);
      tick(1);
      cmp_val(16'(mux), 16'(exp_mux(i / 8, i % 8)));
      cmp_val(status, exp_status(c, 0, 0));
    end
    $display("test channel done");
    for (int i = 0; i < 8; i++) begin
      c = acs_ctrl_t'(14'($urandom));
      c.conversion_launch = 1'b0;
      c.calibration_launch = 1'b0;
      c.interface_mode = 1'b1;
      wr(c);
      tick(1);
      cmp_val(status, exp_status(c, 0, 0));
      cmp_val(16'(status_sel), 16'(c.read_source == RD_STATUS));
      rd_done = 1'b1;
      tick(1);
      rd_done = 1'b0;
      tick(1);
      c.interface_mode = 1'b0;
      cmp_val(status, exp_status(c, 0, 0));
    end
    $display("test status done");
    for (int i = 0; i < 2; i++) begin
      delay = (i == 0) ? 4'h1 : 4'($urandom_range(9, 2));
      c = CTRL_RST;
      c.conversion_launch = 1'b1;
      wr(c);
      cmp_val(16'(conv_start), 16'h0001);
      tick(1);
      cmp_val(16'(conv_start), 16'h0000);
      cmp_val(status, exp_status(c, 1, 0));
      wait_idle();
      cmp_val(status, STATUS_RST);
    end
    $display("test conversion done");
    for (int i = 0; i < 8; i++) begin
      delay = 4'($urandom_range(4, 1));
      c = CTRL_RST;
      c.calibration_kind = i[2];
      c.calibration_choice = 2'(i);
      c.calibration_launch = 1'b1;
      exp_q = {};
      got_q = {};
      if (c.calibration_choice == CAL_FULL) exp_q.push_back(CS_DAC);
      if (c.calibration_choice != CAL_OFFS_ONLY) exp_q.push_back(CS_GAIN);
      if (c.calibration_choice != CAL_GAIN_ONLY) exp_q.push_back(CS_OFFS);
      wr(c);
      for (k = 0; k < 300; k++) begin
        if (step_start === 1'b1) got_q.push_back(step);
        if (k == 1) cmp_val(status, exp_status(c, 1, 1));
        if (k == 1) cmp_val(16'(cal_sys), 16'(c.calibration_kind));
        if (k > 1 && status[ST_CAL] === 1'b0) break;
        tick(1);
      end
      if (k == 300) timed_out();
      cmp_val(16'(got_q.size()), 16'(exp_q.size()));
      for (int j = 0; j < exp_q.size(); j++) begin
        cmp_step(j < got_q.size() ? got_q[j] : CS_IDLE, exp_q[j]);
      end
      c.calibration_launch = 1'b0;
      cmp_val(status, exp_status(c, 0, 0));
      cmp_step(step, CS_IDLE);
    end
    $display("test calibration done");
    conclude();
  end
endmodule
`default_nettype wire
